// ---- scs_system_control.sv ----
// system control and status register bank on ahb-lite
// assumes reset_n and porReset_n asynchronous active low, pins synchronous
// assumes single word transfers; hsize is not decoded
// What this block does
// [R1] wait keeps pll and peripheral bus running; stop halts both
// [R2] either sleep mode puts the adc in low power
// [R3] stop mode clocks the core straight from the oscillator
// [R4] reserved control and status bits ignore writes and read zero
// [R5] control bits 11 and 10 disable timer and strobe pin pull-ups
// [R6] control bits 9 and 8 disable low address and data pull-ups
// [R7] control bit 4 picks the program map when both mode bits are zero
// [R8] mode decode: boot, half internal, development, others reserved
// [R9] control bits 3 and 2 enable the two low-voltage interrupts
// [R10] permanent sleep block stays set until reset; sleeps become loops
// [R11] reprogrammable sleep block set and cleared freely; sleeps become loops
// [R12] status flags ignore system reset; only power-on reset loads their reset values
// [R13] status bit 4 marks a watchdog reset
// [R14] writing zero sets a status flag, writing one clears it
// [R15] status bit 3 marks an external pin reset
// [R16] status bit 2 set by power-on reset, cleared only by software
// [R17] status bit 1 marks supply below 2.7 V, interrupts if enabled
// [R18] status bit 0 marks supply below 2.2 V, interrupts if enabled
// [R19] two read-only registers give the id code halves
// [R20] test scratch register is plain read/write storage
// [R21] both mode bits are captured from the boot pin at reset
// [R22] hardware set wins over a same-cycle software clear
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scs_system_control
  import scs_pkg::*;
#(
  parameter logic [15:0] ID_UPPER = 16'h0a5a, // arbitrary value
  parameter logic [15:0] ID_LOWER = 16'h1234, // arbitrary value
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic porReset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_WIDTH-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // reset causes and supply monitors
  input wire logic watchdogResetEvent,
  input wire logic pinResetEvent,
  input wire logic lowVoltHigh,
  input wire logic lowVoltLow,
  input wire logic bootSelectPin,
  // core sleep handshake
  input wire logic waitRequest,
  input wire logic stopRequest,
  input wire logic wakeUp,
  // outputs to the chip
  output logic timerPullupOff,
  output logic strobePullupOff,
  output logic lowAddressPullupOff,
  output logic databusPullupOff,
  output logic lowVoltHighIrq,
  output logic lowVoltLowIrq,
  output scs_map_t programMap,
  output logic bootModeBitA,
  output logic bootModeBitB,
  output logic coreSleep,
  output logic pllRun,
  output logic periphBusRun,
  output logic adcLowPower,
  output logic coreClockFromOsc,
  output logic sleepAsLoop
);
  // refuse address widths the offset decode cannot serve
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : gBadAddrWidth
    $error("scs_system_control: ADDR_WIDTH must lie between 8 and 32");
  end

  typedef struct packed {
    logic [15:0] control;
    logic [15:0] scratch;
    logic bootA;
    logic bootB;
    logic captured;
    logic wrPending;
    logic [7:0] wrOffset;
    logic [31:0] rdata;
  } scs_state_t;
  scs_state_t state_reg;
  scs_state_t state_next;

  // status flag bank
  logic [4:0] statusFlags;
  logic [4:0] flagHwSet;
  logic [4:0] flagSwWrite;
  // address phase decode
  logic addrPhase;
  logic addrRead;
  logic [7:0] addrOffset;
  logic selControl;
  logic selStatus;
  logic selIdUpper;
  logic selIdLower;
  logic selScratch;
  // data phase decode
  logic [15:0] wdata16;
  logic wrControl;
  logic wrStatus;
  logic wrScratch;
  // register images
  logic [15:0] statusWord;
  logic [15:0] controlWord;
  logic [15:0] controlWritten;
  logic [15:0] readWord;
  // sleep blocking and interrupt enables
  logic sleepBlocked;
  logic lowVoltHighEnable;
  logic lowVoltLowEnable;

  // address phase decode, word aligned
  // upper address bits beyond the bank are not decoded
  assign addrPhase = hsel && hready && htrans[1];
  assign addrRead = addrPhase && !hwrite;
  assign addrOffset = {haddr[7:2], 2'b00};
  assign selControl = (addrOffset == SCS_OFF_CONTROL);
  assign selStatus = (addrOffset == SCS_OFF_STATUS);
  assign selIdUpper = (addrOffset == SCS_OFF_ID_UPPER);
  assign selIdLower = (addrOffset == SCS_OFF_ID_LOWER);
  assign selScratch = (addrOffset == SCS_OFF_SCRATCH);

  // data phase decode; the word stands on hwdata in this cycle
  assign wdata16 = hwdata[15:0];
  assign wrControl = state_reg.wrPending && (state_reg.wrOffset == SCS_OFF_CONTROL);
  assign wrStatus = state_reg.wrPending && (state_reg.wrOffset == SCS_OFF_STATUS);
  assign wrScratch = state_reg.wrPending && (state_reg.wrOffset == SCS_OFF_SCRATCH);

  // register images as software sees them
  assign controlWord = state_reg.control & SCS_CTL_MASK; // [R4]
  assign statusWord = {11'h000, statusFlags}; // [R4]

  // new control value; a write cannot clear the permanent block
  always_comb begin
    controlWritten = wdata16 & SCS_CTL_MASK; // [R4]
    if (state_reg.control[SCS_CTL_PERM]) begin
      controlWritten[SCS_CTL_PERM] = 1'b1; // [R10]
    end
  end

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    readWord = 16'h0000;
    if (selControl) begin
      readWord = controlWord;
    end
    if (selStatus) begin
      readWord = statusWord;
    end
    if (selIdUpper) begin
      readWord = ID_UPPER; // [R19]
    end
    if (selIdLower) begin
      readWord = ID_LOWER; // [R19]
    end
    if (selScratch) begin
      readWord = state_reg.scratch;
    end
  end

  // hardware causes per status bit
  assign flagHwSet[SCS_STS_WDOG] = watchdogResetEvent; // [R13]
  assign flagHwSet[SCS_STS_PIN] = pinResetEvent; // [R15]
  assign flagHwSet[SCS_STS_POR] = 1'b0; // [R16]
  assign flagHwSet[SCS_STS_LVH] = lowVoltHigh; // [R17]
  assign flagHwSet[SCS_STS_LVL] = lowVoltLow; // [R18]

  // software write strobe to every status flag
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      flagSwWrite[i] = wrStatus;
    end
  end

  // status flags, each kept by power-on reset only
  // watchdog reset cause
  scs_status_flag #(
    .RESET_VALUE(SCS_STS_RESET[SCS_STS_WDOG])
  ) uFlagWdog (
    .clock(clock),
    .porReset_n(porReset_n),
    .hwSet(flagHwSet[SCS_STS_WDOG]), // [R13]
    .swWrite(flagSwWrite[SCS_STS_WDOG]),
    .swData(wdata16[SCS_STS_WDOG]), // [R14]
    .flag(statusFlags[SCS_STS_WDOG])
  );

  // external pin reset cause
  scs_status_flag #(
    .RESET_VALUE(SCS_STS_RESET[SCS_STS_PIN])
  ) uFlagPin (
    .clock(clock),
    .porReset_n(porReset_n),
    .hwSet(flagHwSet[SCS_STS_PIN]), // [R15]
    .swWrite(flagSwWrite[SCS_STS_PIN]),
    .swData(wdata16[SCS_STS_PIN]), // [R14]
    .flag(statusFlags[SCS_STS_PIN])
  );

  // power-on reset cause, set by its own reset value
  scs_status_flag #(
    .RESET_VALUE(SCS_STS_RESET[SCS_STS_POR]) // [R16]
  ) uFlagPor (
    .clock(clock),
    .porReset_n(porReset_n),
    .hwSet(flagHwSet[SCS_STS_POR]),
    .swWrite(flagSwWrite[SCS_STS_POR]),
    .swData(wdata16[SCS_STS_POR]), // [R14]
    .flag(statusFlags[SCS_STS_POR])
  );

  // supply below the upper threshold
  scs_status_flag #(
    .RESET_VALUE(SCS_STS_RESET[SCS_STS_LVH])
  ) uFlagLvh (
    .clock(clock),
    .porReset_n(porReset_n),
    .hwSet(flagHwSet[SCS_STS_LVH]), // [R17]
    .swWrite(flagSwWrite[SCS_STS_LVH]),
    .swData(wdata16[SCS_STS_LVH]), // [R14]
    .flag(statusFlags[SCS_STS_LVH])
  );

  // supply below the lower threshold
  scs_status_flag #(
    .RESET_VALUE(SCS_STS_RESET[SCS_STS_LVL])
  ) uFlagLvl (
    .clock(clock),
    .porReset_n(porReset_n),
    .hwSet(flagHwSet[SCS_STS_LVL]), // [R18]
    .swWrite(flagSwWrite[SCS_STS_LVL]),
    .swData(wdata16[SCS_STS_LVL]), // [R14]
    .flag(statusFlags[SCS_STS_LVL])
  );

  // bus writes, read capture and boot pin capture
  always_comb begin
    state_next = state_reg;
    state_next.wrPending = 1'b0;
    if (!state_reg.captured) begin
      state_next.bootA = bootSelectPin; // [R21]
      state_next.bootB = bootSelectPin; // [R21]
      state_next.captured = 1'b1;
    end
    // data phase of a write; id and unmapped offsets ignore it [R19]
    if (wrControl) begin
      state_next.control = controlWritten; // [R4] [R10]
    end
    if (wrScratch) begin
      state_next.scratch = wdata16; // [R20]
    end
    // address phase: remember a write, or load read data
    if (addrPhase) begin
      state_next.wrPending = hwrite;
      state_next.wrOffset = addrOffset;
      state_next.rdata = 32'h0000_0000;
      if (addrRead) begin
        state_next.rdata = {16'h0000, readWord};
      end
    end
  end

  // system reset clears control, scratch and the pin capture
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // status flags live in their own power-on domain
      state_reg <= '{
        control: SCS_CTL_RESET, // [R10]
        scratch: SCS_SCRATCH_RESET,
        bootA: 1'b0,
        bootB: 1'b0,
        captured: 1'b0,
        wrPending: 1'b0,
        wrOffset: 8'h00,
        rdata: 32'h0000_0000
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // bus answers in zero wait states, always okay
  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // pin pull-up controls
  assign timerPullupOff = state_reg.control[SCS_CTL_TIMER_PU]; // [R5]
  assign strobePullupOff = state_reg.control[SCS_CTL_STROBE_PU]; // [R5]
  assign lowAddressPullupOff = state_reg.control[SCS_CTL_ADDR_PU]; // [R6]
  assign databusPullupOff = state_reg.control[SCS_CTL_DATA_PU]; // [R6]

  // low-voltage interrupt enables
  assign lowVoltHighEnable = state_reg.control[SCS_CTL_LVH_IE]; // [R9]
  assign lowVoltLowEnable = state_reg.control[SCS_CTL_LVL_IE]; // [R9]

  // low-voltage interrupts follow their flags while enabled
  assign lowVoltHighIrq = statusFlags[SCS_STS_LVH] && lowVoltHighEnable; // [R17]
  assign lowVoltLowIrq = statusFlags[SCS_STS_LVL] && lowVoltLowEnable; // [R18]

  // memory map decode from mode bits and bootmap
  assign bootModeBitA = state_reg.bootA;
  assign bootModeBitB = state_reg.bootB;
  always_comb begin
    case ({state_reg.bootA, state_reg.bootB})
      2'b00: programMap = state_reg.control[SCS_CTL_BOOTMAP] ? SCS_MAP_HALF : SCS_MAP_BOOT; // [R7] [R8]
      2'b11: programMap = SCS_MAP_DEVEL; // [R8]
      2'b01: programMap = SCS_MAP_RSVD; // [R8]
      2'b10: programMap = SCS_MAP_RSVD; // [R8]
      default: programMap = SCS_MAP_RSVD;
    endcase
  end

  // either block bit turns sleep instructions into loops
  assign sleepBlocked = state_reg.control[SCS_CTL_PERM] | state_reg.control[SCS_CTL_REPROG]; // [R10] [R11]

  // sleep handling
  scs_power_ctrl uPower (
    .clock(clock),
    .reset_n(reset_n),
    .waitRequest(waitRequest),
    .stopRequest(stopRequest),
    .wakeUp(wakeUp),
    .sleepBlocked(sleepBlocked),
    .coreSleep(coreSleep),
    .pllRun(pllRun),
    .periphBusRun(periphBusRun),
    .adcLowPower(adcLowPower),
    .coreClockFromOsc(coreClockFromOsc),
    .sleepAsLoop(sleepAsLoop)
  );
endmodule // scs_system_control
`default_nettype wire

// ---- scs_pkg.sv ----
// system control and status block: shared constants and types
// assumes a 32-bit ahb-lite register bus and a 25 MHz system clock
package scs_pkg;
  // register byte offsets
  localparam logic [7:0] SCS_OFF_CONTROL = 8'h00;
  localparam logic [7:0] SCS_OFF_STATUS = 8'h04;
  localparam logic [7:0] SCS_OFF_ID_UPPER = 8'h08;
  localparam logic [7:0] SCS_OFF_ID_LOWER = 8'h0c;
  localparam logic [7:0] SCS_OFF_SCRATCH = 8'h10;
  // control field positions
  localparam int SCS_CTL_TIMER_PU = 11;
  localparam int SCS_CTL_STROBE_PU = 10;
  localparam int SCS_CTL_ADDR_PU = 9;
  localparam int SCS_CTL_DATA_PU = 8;
  localparam int SCS_CTL_BOOTMAP = 4;
  localparam int SCS_CTL_LVH_IE = 3;
  localparam int SCS_CTL_LVL_IE = 2;
  localparam int SCS_CTL_PERM = 1;
  localparam int SCS_CTL_REPROG = 0;
  // writable control bits; the rest read zero
  localparam logic [15:0] SCS_CTL_MASK = 16'h0f1f;
  localparam logic [15:0] SCS_CTL_RESET = 16'h0000;
  // status field positions
  localparam int SCS_STS_WDOG = 4;
  localparam int SCS_STS_PIN = 3;
  localparam int SCS_STS_POR = 2;
  localparam int SCS_STS_LVH = 1;
  localparam int SCS_STS_LVL = 0;
  localparam logic [4:0] SCS_STS_RESET = 5'h04;
  localparam logic [15:0] SCS_SCRATCH_RESET = 16'h0000;
  // program memory map decode
  typedef enum logic [2:0] {
    SCS_MAP_BOOT = 3'h0,
    SCS_MAP_HALF = 3'h1,
    SCS_MAP_DEVEL = 3'h3,
    SCS_MAP_RSVD = 3'h2
  } scs_map_t;
  // core power state, gray coded along run-wait/run-stop
  typedef enum logic [1:0] {
    SCS_PWR_RUN = 2'h0,
    SCS_PWR_WAIT = 2'h1,
    SCS_PWR_STOP = 2'h2
  } scs_pwr_t;
endpackage

// ---- scs_status_flag.sv ----
// one sticky status flag: hardware set, software write-0 sets, write-1 clears
// assumes the caller qualifies the write strobe with a valid bus write
`timescale 1ns/1ps
`default_nettype none
module scs_status_flag
  import scs_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clock,
  input wire logic porReset_n,
  input wire logic hwSet,
  input wire logic swWrite,
  input wire logic swData,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } scs_flag_state_t;
  scs_flag_state_t state_reg;
  scs_flag_state_t state_next;

  // hardware set beats a software clear
  always_comb begin
    state_next = state_reg;
    if (swWrite) begin
      state_next.flag = ~swData; // [R14]
    end
    if (hwSet) begin
      state_next.flag = 1'b1; // [R22]
    end
  end

  // only power-on reset loads the flag with its reset value
  always_ff @(posedge clock or negedge porReset_n) begin
    if (!porReset_n) begin
      state_reg <= '{flag: RESET_VALUE}; // [R12]
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag = state_reg.flag;
endmodule // scs_status_flag
`default_nettype wire

// ---- scs_power_ctrl.sv ----
// sleep control: turns sleep requests into wait/stop and clock/bus gating
// assumes one-cycle request pulses from the core and a one-cycle wake pulse
`timescale 1ns/1ps
`default_nettype none
module scs_power_ctrl
  import scs_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic waitRequest,
  input wire logic stopRequest,
  input wire logic wakeUp,
  input wire logic sleepBlocked,
  output logic coreSleep,
  output logic pllRun,
  output logic periphBusRun,
  output logic adcLowPower,
  output logic coreClockFromOsc,
  output logic sleepAsLoop
);
  typedef struct packed {
    scs_pwr_t pwr;
    logic loopPulse;
  } scs_pwr_state_t;
  scs_pwr_state_t state_reg;
  scs_pwr_state_t state_next;

  // enter wait or stop unless blocked; blocked requests loop
  always_comb begin
    state_next = state_reg;
    state_next.loopPulse = 1'b0;
    case (state_reg.pwr)
      SCS_PWR_RUN: begin
        if ((waitRequest || stopRequest) && sleepBlocked) begin
          state_next.loopPulse = 1'b1; // [R10] [R11]
        end else if (stopRequest) begin
          state_next.pwr = SCS_PWR_STOP;
        end else if (waitRequest) begin
          state_next.pwr = SCS_PWR_WAIT;
        end
      end
      SCS_PWR_WAIT, SCS_PWR_STOP: begin
        if (wakeUp) begin
          state_next.pwr = SCS_PWR_RUN;
        end
      end
      default: state_next.pwr = SCS_PWR_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{pwr: SCS_PWR_RUN, loopPulse: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // gating follows the registered state
  assign coreSleep = (state_reg.pwr != SCS_PWR_RUN);
  assign pllRun = (state_reg.pwr != SCS_PWR_STOP); // [R1]
  assign periphBusRun = (state_reg.pwr != SCS_PWR_STOP); // [R1]
  assign adcLowPower = coreSleep; // [R2]
  assign coreClockFromOsc = (state_reg.pwr == SCS_PWR_STOP); // [R3]
  assign sleepAsLoop = state_reg.loopPulse;
endmodule // scs_power_ctrl
`default_nettype wire

// ---- scs_system_control_props.sv ----
// checker for the system control bank: bus reads, pull-ups, sleep, map
// bound to scs_system_control and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module scs_system_control_props
  import scs_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic porReset_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic bootSelectPin,
  input wire logic waitRequest,
  input wire logic stopRequest,
  input wire logic wakeUp,
  input wire logic timerPullupOff,
  input wire logic strobePullupOff,
  input wire logic lowAddressPullupOff,
  input wire logic databusPullupOff,
  input wire scs_map_t programMap,
  input wire logic bootModeBitA,
  input wire logic bootModeBitB,
  input wire logic coreSleep,
  input wire logic pllRun,
  input wire logic periphBusRun,
  input wire logic adcLowPower,
  input wire logic coreClockFromOsc,
  input wire logic sleepAsLoop
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n || !porReset_n);
  // address phase then its data phase
  sequence ctlWrite;
    hsel && hready && htrans[1] && hwrite && haddr == SCS_OFF_CONTROL ##1 1'b1;
  endsequence
  sequence anyRead(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == a ##1 1'b1;
  endsequence
  sequence sleepReq;
    (waitRequest || stopRequest) && !coreSleep && !wakeUp;
  endsequence
  a_ctl_read_zero: assert property (anyRead(SCS_OFF_CONTROL) |-> hrdata[31:12] == 20'h0 && hrdata[7:5] == 3'h0)
    else $error("control reserved bits not zero");
  a_sts_read_zero: assert property (anyRead(SCS_OFF_STATUS) |-> hrdata[31:5] == 27'h0)
    else $error("status reserved bits not zero");
  a_pullup_follow: assert property (ctlWrite |=> {timerPullupOff, strobePullupOff, lowAddressPullupOff,
    databusPullupOff} == $past(hwdata[11:8]))
    else $error("pull-up outputs differ from written control");
  a_wait_runs_pll: assert property (coreSleep && !coreClockFromOsc |-> pllRun && periphBusRun)
    else $error("wait mode stopped pll or bus");
  a_stop_halts_all: assert property (coreClockFromOsc |-> coreSleep && !pllRun && !periphBusRun)
    else $error("stop mode left pll or bus running");
  a_sleep_adc_low: assert property (coreSleep |-> adcLowPower)
    else $error("adc not low power while asleep");
  a_stop_from_osc: assert property (stopRequest && !waitRequest && !coreSleep && !wakeUp ##1 coreSleep
    |-> coreClockFromOsc)
    else $error("stop did not take core clock from oscillator");
  a_sleep_or_loop: assert property (sleepReq |=> coreSleep != sleepAsLoop)
    else $error("request neither slept nor looped");
  a_loop_has_cause: assert property (sleepAsLoop |-> $past(waitRequest || stopRequest) && !coreSleep)
    else $error("loop pulse without blocked request");
  a_mode_capture: assert property ($rose(reset_n) |=> bootModeBitA == $past(bootSelectPin)
    && bootModeBitB == $past(bootSelectPin))
    else $error("mode bits not taken from boot pin");
  a_map_devel: assert property (bootModeBitA && bootModeBitB |-> programMap == SCS_MAP_DEVEL)
    else $error("development map not decoded");
  a_map_internal: assert property (!bootModeBitA && !bootModeBitB
    |-> programMap inside {SCS_MAP_BOOT, SCS_MAP_HALF})
    else $error("internal map decode wrong");
endmodule // scs_system_control_props
bind scs_system_control scs_system_control_props u_props (.*);
`default_nettype wire

// ---- system_control_status_test.sv ----
// self-checking bench for the system control bank
// drives the ports as an ahb-lite master at 25 MHz; hready is looped back from hreadyout
`timescale 1ns/1ps
`default_nettype none
module system_control_status_test
  import scs_pkg::*;
;
  localparam logic [15:0] ID_HI = 16'h3c96; // arbitrary value
  localparam logic [15:0] ID_LO = 16'h7e41; // arbitrary value
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic porReset_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] evt = 4'h0; // watchdog, pin, high, low
  logic [2:0] slp = 3'h0; // wait, stop, wake
  logic bootSelectPin = 1'b1;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] pull;
  logic [1:0] irq;
  logic [4:0] pwr; // sleep, pll, bus, adc, osc
  logic modeA, modeB, sleepAsLoop;
  scs_map_t programMap;
  int errCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  assign hready = hreadyout;
  scs_system_control #(.ID_UPPER(ID_HI), .ID_LOWER(ID_LO)) DUT (.clock(clock), .reset_n(reset_n),
    .porReset_n(porReset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .watchdogResetEvent(evt[3]), .pinResetEvent(evt[2]), .lowVoltHigh(evt[1]), .lowVoltLow(evt[0]),
    .bootSelectPin(bootSelectPin), .waitRequest(slp[2]), .stopRequest(slp[1]), .wakeUp(slp[0]),
    .timerPullupOff(pull[3]), .strobePullupOff(pull[2]), .lowAddressPullupOff(pull[1]),
    .databusPullupOff(pull[0]), .lowVoltHighIrq(irq[1]), .lowVoltLowIrq(irq[0]), .programMap(programMap),
    .bootModeBitA(modeA), .bootModeBitB(modeB), .coreSleep(pwr[4]), .pllRun(pwr[3]), .periphBusRun(pwr[2]),
    .adcLowPower(pwr[1]), .coreClockFromOsc(pwr[0]), .sleepAsLoop(sleepAsLoop));
  // 40 ns clock
  always #20 clock = ~clock;
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      finalReport();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single transfer, address phase then data phase
  task automatic busCycle(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    #1;
  endtask
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busCycle(a, 1'b1, d, q);
  endtask
  task automatic expectReg(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busCycle(a, 1'b0, 32'h0, q);
    check(what, exp, q);
    check("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic pulseSleep(input logic [2:0] v);
    slp <= v;
    @(posedge clock);
    slp <= 3'h0;
    #1;
  endtask
  task automatic pulseEvt(input logic [3:0] v);
    evt <= v;
    @(posedge clock);
    evt <= 4'h0;
    #1;
  endtask
  task automatic testResetValues();
    check("mode", 32'h3, 32'({modeA, modeB}));
    check("map", 32'(SCS_MAP_DEVEL), 32'(programMap));
    expectReg("control", SCS_OFF_CONTROL, 32'h0);
    expectReg("status", SCS_OFF_STATUS, 32'h4);
    busWrite(SCS_OFF_ID_UPPER, 32'hffff);
    busWrite(8'h14, 32'hffff);
    expectReg("idUpper", SCS_OFF_ID_UPPER, 32'(ID_HI));
    expectReg("idLower", SCS_OFF_ID_LOWER, 32'(ID_LO));
    expectReg("unmapped", 8'h14, 32'h0);
    busWrite(SCS_OFF_SCRATCH, 32'h1234a5c3);
    expectReg("scratch", SCS_OFF_SCRATCH, 32'ha5c3);
    $display("reset values done");
  endtask
  task automatic testSleep();
    pulseSleep(3'h4);
    check("waitPower", 32'h1e, 32'(pwr));
    pulseSleep(3'h1);
    check("wokeWait", 32'h0c, 32'(pwr));
    pulseSleep(3'h2);
    check("stopPower", 32'h13, 32'(pwr));
    pulseSleep(3'h1);
    busWrite(SCS_OFF_CONTROL, 32'h1);
    pulseSleep(3'h2);
    check("loop", 32'h1, 32'(sleepAsLoop));
    check("loopRun", 32'h0c, 32'(pwr));
    busWrite(SCS_OFF_CONTROL, 32'h0);
    pulseSleep(3'h4);
    check("unblocked", 32'h1e, 32'(pwr));
    pulseSleep(3'h1);
    $display("sleep done");
  endtask
  task automatic testStatusFlags();
    busWrite(SCS_OFF_STATUS, 32'hffff);
    expectReg("clearAll", SCS_OFF_STATUS, 32'h0);
    busWrite(SCS_OFF_STATUS, 32'h0);
    expectReg("setAll", SCS_OFF_STATUS, 32'h1f);
    busWrite(SCS_OFF_STATUS, 32'h1f);
    busWrite(SCS_OFF_CONTROL, 32'hc);
    for (int i = 0; i < 4; i++) begin
      pulseEvt(4'h1 << i);
      expectReg("hwFlag", SCS_OFF_STATUS, 32'(i < 2 ? 1 << i : 2 << i));
      check("irq", 32'(i < 2 ? 1 << i : 0), 32'(irq));
      busWrite(SCS_OFF_STATUS, 32'h1f);
    end
    busWrite(SCS_OFF_CONTROL, 32'h0);
    pulseEvt(4'h2);
    check("masked", 32'h0, 32'(irq));
    evt <= 4'h1;
    busWrite(SCS_OFF_STATUS, 32'h1f);
    evt <= 4'h0;
    expectReg("setWins", SCS_OFF_STATUS, 32'h1);
    busWrite(SCS_OFF_STATUS, 32'h1f);
    $display("status flags done");
  endtask
  task automatic testControl();
    for (int i = 0; i < 4; i++) begin
      busWrite(SCS_OFF_CONTROL, 32'h100 << i);
      check("pullBit", 32'(1 << i), 32'(pull));
    end
    busWrite(SCS_OFF_CONTROL, 32'hffffffff);
    expectReg("ctlMask", SCS_OFF_CONTROL, 32'h0f1f);
    busWrite(SCS_OFF_CONTROL, 32'h0);
    expectReg("permSticks", SCS_OFF_CONTROL, 32'h2);
    check("pullOn", 32'h0, 32'(pull));
    pulseSleep(3'h4);
    check("permLoop", 32'h1, 32'(sleepAsLoop));
    check("permRun", 32'h0c, 32'(pwr));
    $display("control done");
  endtask
  task automatic testModeReset();
    pulseEvt(4'h4);
    bootSelectPin <= 1'b0;
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("modeBoot", 32'h0, 32'({modeA, modeB}));
    check("mapBoot", 32'(SCS_MAP_BOOT), 32'(programMap));
    expectReg("ctlCleared", SCS_OFF_CONTROL, 32'h0);
    expectReg("flagsKept", SCS_OFF_STATUS, 32'h8);
    busWrite(SCS_OFF_CONTROL, 32'h10);
    check("mapHalf", 32'(SCS_MAP_HALF), 32'(programMap));
    $display("mode and reset done");
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    porReset_n <= 1'b1;
    @(posedge clock);
    #1;
    testResetValues();
    testSleep();
    testStatusFlags();
    testControl();
    testModeReset();
    finalReport();
  end
endmodule // system_control_status_test
`default_nettype wire
